// ### rtl/instr_format_and_address_gen.v
// Behaviour
// - halfword access clears address bit zero
// - word access clears two lowest address bits
// - multibyte data is little-endian
// - signed operands are two's complement
// - pc steps two or four bytes
// - relative target is pc plus sign-extended displacement
// - indirect jump loads pc from register
// - immediate operand comes from instruction field
// - based address is register plus displacement
// - low instruction part from lower address
// - register-register format, sixteen bits
// - immediate-register format, sixteen bits
// - conditional branch format, sixteen bits
// - medium jump format, thirty-two bits
// - three-operand format, thirty-two bits
// - load/store format, thirty-two bits
// - extended format, thirty-two bits
// - three-register format, thirty-two bits
// - no-operand format, sixteen bits
// - full 32-bit memory and io addresses
// - pc bit zero always zero
`include "instr_fmt_consts.vh"

module instr_format_and_address_gen #(
  parameter PC_INIT = `PC_RESET
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        fetch_valid,
  input  wire [15:0] fetch_lo_half,
  input  wire [15:0] fetch_hi_half,
  input  wire        take_branch,
  input  wire        jump_rel,
  input  wire        register_indirect_jump,
  input  wire [31:0] source_reg_val,
  input  wire        mem_req,
  input  wire        io_space,
  input  wire [1:0]  acc_size,
  input  wire        sign_load,
  input  wire [31:0] store_val,
  input  wire [31:0] bus_rdata,
  output reg  [31:0] pc_r,
  output reg  [31:0] link_addr_r,
  output reg         dec_valid_r,
  output reg         dec_long_r,
  output reg  [8:0]  dec_fmt_r,
  output reg  [5:0]  dec_opcode_r,
  output reg  [4:0]  dec_src_reg_r,
  output reg  [4:0]  dec_second_reg_r,
  output reg  [4:0]  dec_third_reg_r,
  output reg  [5:0]  dec_subop_r,
  output reg         dec_subop_bit_r,
  output reg  [3:0]  dec_cond_r,
  output reg  [31:0] imm_operand_r,
  output reg  [31:0] imm_signed_r,
  output reg         mem_valid_r,
  output reg         mem_io_r,
  output reg  [31:0] mem_addr_r,
  output reg  [3:0]  mem_byte_en_r,
  output reg  [31:0] mem_wdata_r,
  output reg  [31:0] load_val_r
);

  // ---------------------------------------------------------------
  // instruction assembly
  // ---------------------------------------------------------------
  // first halfword (lower address) holds bit 0 and the opcode
  wire [31:0] iword = {fetch_hi_half, fetch_lo_half};

  wire                 is_long;
  wire [`FMT_W-1:0]    fmt;
  wire [5:0]           opcode;
  wire [4:0]           source_reg_field;
  wire [4:0]           second_reg_field;
  wire [4:0]           third_reg_field;
  wire [5:0]           sub_op6;
  wire                 sub_op1;
  wire [3:0]           cond_code;
  wire [4:0]           short_immediate;
  wire [15:0]          long_immediate;
  wire [8:0]           bdisp9;
  wire [25:0]          jdisp26;

  field_split u_split (
    .iword            (iword),
    .is_long          (is_long),
    .fmt              (fmt),
    .opcode           (opcode),
    .source_reg_field (source_reg_field),
    .second_reg_field (second_reg_field),
    .third_reg_field  (third_reg_field),
    .sub_op6          (sub_op6),
    .sub_op1          (sub_op1),
    .cond_code        (cond_code),
    .short_immediate  (short_immediate),
    .long_immediate   (long_immediate),
    .bdisp9           (bdisp9),
    .jdisp26          (jdisp26)
  );

  // ---------------------------------------------------------------
  // immediate operands
  // ---------------------------------------------------------------
  reg [31:0] imm_raw;
  reg [31:0] imm_sext;

  always @* begin
    imm_raw  = 32'h00000000;
    imm_sext = 32'h00000000;
    if (fmt == `FMT_II) begin
      imm_raw  = {27'h0, short_immediate};
      imm_sext = {{27{short_immediate[4]}}, short_immediate};
    end else if (fmt == `FMT_V || fmt == `FMT_VI) begin
      imm_raw  = {16'h0, long_immediate};
      imm_sext = {{16{long_immediate[15]}}, long_immediate};
    end
  end

  // ---------------------------------------------------------------
  // next program counter
  // ---------------------------------------------------------------
  wire [31:0] pc_step = is_long ? `PC_STEP_LONG : `PC_STEP_SHORT;
  wire [31:0] rel_off = (fmt == `FMT_III)
                      ? {{23{bdisp9[`BDISP_SIGN]}}, bdisp9}
                      : {{6{jdisp26[`JDISP_SIGN]}}, jdisp26};
  reg  [1:0]  npc_sel;
  reg  [31:0] pc_nxt;

  always @* begin
    npc_sel = `NPC_SEQ;
    if (register_indirect_jump)
      npc_sel = `NPC_REG;
    else if (take_branch || jump_rel)
      npc_sel = `NPC_REL;
    case (npc_sel)
      `NPC_REL: pc_nxt = pc_r + rel_off;
      `NPC_REG: pc_nxt = source_reg_val;
      default:  pc_nxt = pc_r + pc_step;
    endcase
    pc_nxt = {pc_nxt[31:1], 1'b0};
  end

  // ---------------------------------------------------------------
  // data address generation
  // ---------------------------------------------------------------
  // full 32-bit sum; wraps modulo 4G like the linear space itself
  wire [31:0] based_operand = source_reg_val
                            + {{16{long_immediate[15]}}, long_immediate};
  wire [31:0] algn_addr;
  wire [31:0] algn_wdata;
  wire [3:0]  algn_be;
  wire [31:0] algn_load;

  data_align u_align (
    .addr_raw  (based_operand),
    .acc_size  (acc_size),
    .store_val (store_val),
    .bus_rdata (bus_rdata),
    .sign_load (sign_load),
    .addr_out  (algn_addr),
    .bus_wdata (algn_wdata),
    .byte_en   (algn_be),
    .load_val  (algn_load)
  );

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      pc_r             <= PC_INIT;
      link_addr_r      <= 32'h00000000;
      dec_valid_r      <= 1'b0;
      dec_long_r       <= 1'b0;
      dec_fmt_r        <= `FMT_I;
      dec_opcode_r     <= 6'h00;
      dec_src_reg_r    <= 5'h00;
      dec_second_reg_r <= 5'h00;
      dec_third_reg_r  <= 5'h00;
      dec_subop_r      <= 6'h00;
      dec_subop_bit_r  <= 1'b0;
      dec_cond_r       <= 4'h0;
      imm_operand_r    <= 32'h00000000;
      imm_signed_r     <= 32'h00000000;
      mem_valid_r      <= 1'b0;
      mem_io_r         <= 1'b0;
      mem_addr_r       <= 32'h00000000;
      mem_byte_en_r    <= 4'h0;
      mem_wdata_r      <= 32'h00000000;
      load_val_r       <= 32'h00000000;
    end else begin
      dec_valid_r <= fetch_valid;
      mem_valid_r <= fetch_valid & mem_req;
      load_val_r  <= algn_load;
      if (fetch_valid) begin
        pc_r             <= pc_nxt;
        link_addr_r      <= pc_r + `PC_STEP_LONG;
        dec_long_r       <= is_long;
        dec_fmt_r        <= fmt;
        dec_opcode_r     <= opcode;
        dec_src_reg_r    <= source_reg_field;
        dec_second_reg_r <= second_reg_field;
        dec_third_reg_r  <= third_reg_field;
        dec_subop_r      <= sub_op6;
        dec_subop_bit_r  <= sub_op1;
        dec_cond_r       <= cond_code;
        imm_operand_r    <= imm_raw;
        imm_signed_r     <= imm_sext;
        if (mem_req) begin
          mem_io_r      <= io_space;
          mem_addr_r    <= algn_addr;
          mem_byte_en_r <= algn_be;
          mem_wdata_r   <= algn_wdata;
        end
      end
    end
  end

endmodule

// ### rtl/instr_fmt_consts.vh
`ifndef INSTR_FMT_CONSTS_VH
`define INSTR_FMT_CONSTS_VH

// ---------------------------------------------------------------
// field positions within an instruction (low halfword first)
// ---------------------------------------------------------------
`define OPC_HI        15
`define OPC_LO        10
`define RSEL1_HI      4
`define RSEL1_LO      0
`define RSEL2_HI      9
`define RSEL2_LO      5
`define RSEL3_HI      31
`define RSEL3_LO      27
`define SUBOP6_HI     21
`define SUBOP6_LO     16
`define SUBOP1_BIT    0
`define COND_HI       12
`define COND_LO       9
`define BOPC_HI       15
`define BOPC_LO       13
`define BDISP_HI      8
`define BDISP_LO      1
`define LONG_IMMEDIATE_HI      31
`define LONG_IMMEDIATE_LO      16
`define DISP26_HI     9
`define DISP26_LO     0
`define BDISP_SIGN    8
`define JDISP_SIGN    25

// ---------------------------------------------------------------
// length decode: opcodes whose top three bits are 101 or 11x are long
// ---------------------------------------------------------------
`define LONG_PREFIX_A 3'h5
`define BRANCH_PREFIX 3'h4

// ---------------------------------------------------------------
// pc and access encodings
// ---------------------------------------------------------------
`define PC_STEP_SHORT 32'h00000002
`define PC_STEP_LONG  32'h00000004
`define PC_RESET      32'hFFFFFFF0
`define SZ_BYTE       2'h0
`define SZ_HALF       2'h1
`define SZ_WORD       2'h2

// ---------------------------------------------------------------
// format codes (one-hot, bit n-1 for format n)
// ---------------------------------------------------------------
`define FMT_W         9
`define FMT_I         9'h001
`define FMT_II        9'h002
`define FMT_III       9'h004
`define FMT_IV        9'h008
`define FMT_V         9'h010
`define FMT_VI        9'h020
`define FMT_VII       9'h040
`define FMT_VIII      9'h080
`define FMT_IX        9'h100

// ---------------------------------------------------------------
// next-pc select
// ---------------------------------------------------------------
`define NPC_SEQ       2'h0
`define NPC_REL       2'h1
`define NPC_REG       2'h2

`endif

// ### rtl/data_align.v
`include "instr_fmt_consts.vh"

module data_align (
  input  wire [31:0] addr_raw,
  input  wire [1:0]  acc_size,
  input  wire [31:0] store_val,
  input  wire [31:0] bus_rdata,
  input  wire        sign_load,
  output reg  [31:0] addr_out,
  output reg  [31:0] bus_wdata,
  output reg  [3:0]  byte_en,
  output reg  [31:0] load_val
);

  reg [7:0]  b_sel;
  reg [15:0] h_sel;

  always @* begin
    addr_out = addr_raw;
    case (acc_size)
      `SZ_HALF: addr_out = {addr_raw[31:1], 1'b0};
      `SZ_WORD: addr_out = {addr_raw[31:2], 2'b00};
      default:  addr_out = addr_raw;
    endcase
  end

  // lane placement: lowest address carries the least significant byte
  always @* begin
    bus_wdata = 32'h00000000;
    byte_en   = 4'h0;
    b_sel     = 8'h00;
    h_sel     = 16'h0000;
    load_val  = 32'h00000000;
    case (acc_size)
      `SZ_BYTE: begin
        bus_wdata = {4{store_val[7:0]}};
        byte_en   = 4'h1 << addr_out[1:0];
        b_sel     = bus_rdata[8*addr_out[1:0] +: 8];
        load_val  = {{24{sign_load & b_sel[7]}}, b_sel};
      end
      `SZ_HALF: begin
        bus_wdata = {2{store_val[15:0]}};
        byte_en   = addr_out[1] ? 4'hC : 4'h3;
        h_sel     = addr_out[1] ? bus_rdata[31:16] : bus_rdata[15:0];
        load_val  = {{16{sign_load & h_sel[15]}}, h_sel};
      end
      default: begin
        bus_wdata = store_val;
        byte_en   = 4'hF;
        load_val  = bus_rdata;
      end
    endcase
  end

endmodule

// ### rtl/field_split.v
`include "instr_fmt_consts.vh"

module field_split (
  input  wire [31:0]          iword,
  output wire                 is_long,
  output reg  [`FMT_W-1:0]    fmt,
  output wire [5:0]           opcode,
  output wire [4:0]           source_reg_field,
  output wire [4:0]           second_reg_field,
  output wire [4:0]           third_reg_field,
  output wire [5:0]           sub_op6,
  output wire                 sub_op1,
  output wire [3:0]           cond_code,
  output wire [4:0]           short_immediate,
  output wire [15:0]          long_immediate,
  output wire [8:0]           bdisp9,
  output wire [25:0]          jdisp26
);

  // which formats are long is a property of the top opcode bits
  function is_long_op;
    input [5:0] op;
    begin
      is_long_op = (op[5:3] == `LONG_PREFIX_A) || (op[5:4] == 2'b11);
    end
  endfunction

  assign opcode           = iword[`OPC_HI:`OPC_LO];
  assign is_long          = is_long_op(opcode);
  assign source_reg_field = iword[`RSEL1_HI:`RSEL1_LO];
  assign second_reg_field = iword[`RSEL2_HI:`RSEL2_LO];
  assign short_immediate  = iword[`RSEL1_HI:`RSEL1_LO];
  assign cond_code        = iword[`COND_HI:`COND_LO];
  assign bdisp9           = {iword[`BDISP_HI:`BDISP_LO], 1'b0};
  assign sub_op1          = iword[`SUBOP1_BIT];
  assign jdisp26          = {iword[`DISP26_HI:`DISP26_LO], iword[31:17], 1'b0};
  assign long_immediate   = iword[`LONG_IMMEDIATE_HI:`LONG_IMMEDIATE_LO];
  assign sub_op6          = iword[`SUBOP6_HI:`SUBOP6_LO];
  assign third_reg_field  = iword[`RSEL3_HI:`RSEL3_LO];

  // unused fields are expected to be zero by the code producer, so no
  // field is masked here per format; consumers pick by fmt
  always @* begin
    fmt = `FMT_I;
    if (opcode[5:3] == `BRANCH_PREFIX)
      fmt = `FMT_III;
    else if (is_long) begin
      case (opcode[2:0])
        3'h2, 3'h3: fmt = `FMT_IV;
        3'h4:       fmt = `FMT_VII;
        3'h5:       fmt = `FMT_VIII;
        default:    fmt = opcode[5] & opcode[4] ? `FMT_VI : `FMT_V;
      endcase
    end else if (opcode[4])
      fmt = opcode[3] ? `FMT_IX : `FMT_II;
    else
      fmt = `FMT_I;
  end

endmodule

// ### bench/fmt_addr_asserts.sv
module fmt_addr_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_lo_half,
  input wire logic [15:0] fetch_hi_half,
  input wire logic        take_branch,
  input wire logic        jump_rel,
  input wire logic        register_indirect_jump,
  input wire logic [31:0] source_reg_val,
  input wire logic        mem_req,
  input wire logic        io_space,
  input wire logic [1:0]  acc_size,
  input wire logic [31:0] pc_r,
  input wire logic        dec_valid_r,
  input wire logic [5:0]  dec_opcode_r,
  input wire logic        mem_valid_r,
  input wire logic        mem_io_r,
  input wire logic [31:0] mem_addr_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------
  // helpers
  // ------------
  wire logic        is_long = fetch_lo_half[15:13] == 3'h5 || fetch_lo_half[15:14] == 2'h3;
  wire logic        based = fetch_valid && mem_req;
  logic      [31:0] raw_r;
  // unaligned sum kept aside so the aligned output can be compared a cycle later
  always @(posedge clk) raw_r <= source_reg_val + {{16{fetch_hi_half[15]}}, fetch_hi_half};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_byte_based: assert property (based && acc_size == 2'h0 |=> mem_addr_r == raw_r)
    else $error("based byte address wrong");
  a_half_align: assert property (based && acc_size == 2'h1 |=> mem_addr_r == {raw_r[31:1], 1'b0})
    else $error("halfword address not aligned");
  a_word_align: assert property (based && acc_size == 2'h2 |=> mem_addr_r == {raw_r[31:2], 2'h0})
    else $error("word address not aligned");
  a_io_space: assert property (based |=> mem_valid_r && mem_io_r == $past(io_space))
    else $error("space select lost");
  a_seq_step: assert property (fetch_valid && !take_branch && !jump_rel && !register_indirect_jump
    |=> pc_r == $past(pc_r) + ($past(is_long) ? 32'h4 : 32'h2))
    else $error("sequential pc step wrong");
  a_branch_rel: assert property (fetch_valid && take_branch && !register_indirect_jump
    && fetch_lo_half[15:13] == 3'h4 |=> pc_r == $past(pc_r)
    + {{23{$past(fetch_lo_half[8])}}, $past(fetch_lo_half[8:1]), 1'b0})
    else $error("branch target wrong");
  a_indirect_pc: assert property (fetch_valid && register_indirect_jump
    |=> pc_r == {$past(source_reg_val[31:1]), 1'b0})
    else $error("indirect target wrong");
  a_pc_even: assert property (pc_r[0] == 1'b0)
    else $error("pc bit zero set");
  a_opcode_low: assert property (fetch_valid |=> dec_valid_r
    && dec_opcode_r == $past(fetch_lo_half[15:10]))
    else $error("opcode not from low half");
  a_idle_hold: assert property (!fetch_valid |=> !dec_valid_r && $stable(pc_r))
    else $error("pc moved without fetch");
  c_branch: cover property (fetch_valid && take_branch);
  c_word: cover property (based && acc_size == 2'h2);
  c_indirect: cover property (fetch_valid && register_indirect_jump);
endmodule
bind instr_format_and_address_gen fmt_addr_asserts fmt_addr_asserts_inst (.clk, .sys_rst,
  .fetch_valid, .fetch_lo_half, .fetch_hi_half, .take_branch, .jump_rel,
  .register_indirect_jump, .source_reg_val, .mem_req, .io_space, .acc_size, .pc_r,
  .dec_valid_r, .dec_opcode_r, .mem_valid_r, .mem_io_r, .mem_addr_r);

// ### bench/fetch_mem_partner.sv
module fetch_mem_partner (
  input wire logic        sel,
  input wire logic [31:0] addr,
  output logic     [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------
  // data memory
  // ------------
  // each byte holds the low bits of its own address, lowest address in lane 0
  wire logic [31:0] word = {addr[7:2], 2'h3, addr[7:2], 2'h2, addr[7:2], 2'h1, addr[7:2], 2'h0};
  // no stale data when idle, so a late capture cannot pass by luck
  assign rdata = sel ? word : ~word;
endmodule

// ### bench/instr_format_and_address_gen_bench.sv
`include "instr_fmt_consts.vh"
module instr_format_and_address_gen_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, fetch_valid, take_branch, jump_rel, register_indirect_jump;
  logic        mem_req, io_space, sign_load, dec_valid_r, dec_long_r, dec_subop_bit_r;
  logic        mem_valid_r, mem_io_r;
  logic [15:0] fetch_lo_half, fetch_hi_half;
  logic [1:0]  acc_size;
  logic [31:0] source_reg_val, store_val, bus_rdata, pc_r, link_addr_r, imm_operand_r, pc_m;
  logic [31:0] imm_signed_r, mem_addr_r, mem_wdata_r, load_val_r;
  logic [8:0]  dec_fmt_r;
  logic [5:0]  dec_opcode_r, dec_subop_r;
  logic [4:0]  dec_src_reg_r, dec_second_reg_r, dec_third_reg_r;
  logic [3:0]  dec_cond_r, mem_byte_en_r;
  int          n_errors = 0;
  int          n_compared = 0;
  instr_format_and_address_gen instr_format_and_address_gen_inst (.clk, .sys_rst, .fetch_valid,
    .fetch_lo_half, .fetch_hi_half, .take_branch, .jump_rel, .register_indirect_jump,
    .source_reg_val, .mem_req, .io_space, .acc_size, .sign_load, .store_val, .bus_rdata, .pc_r,
    .link_addr_r, .dec_valid_r, .dec_long_r, .dec_fmt_r, .dec_opcode_r, .dec_src_reg_r,
    .dec_second_reg_r, .dec_third_reg_r, .dec_subop_r, .dec_subop_bit_r, .dec_cond_r,
    .imm_operand_r, .imm_signed_r, .mem_valid_r, .mem_io_r, .mem_addr_r, .mem_byte_en_r,
    .mem_wdata_r, .load_val_r);
  fetch_mem_partner fetch_mem_partner_inst (.sel(mem_valid_r), .addr(mem_addr_r), .rdata(bus_rdata));
  // ------------
  // shared tasks
  // ------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // valid is left high so instructions can follow back to back
  task automatic issue(input logic [15:0] lo, input logic [15:0] hi, input logic [3:0] c);
    fetch_lo_half = lo;
    fetch_hi_half = hi;
    {register_indirect_jump, jump_rel, take_branch, mem_req} = c;
    fetch_valid = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic idle;
    fetch_valid = 1'b0;
    {register_indirect_jump, jump_rel, take_branch, mem_req} = 4'h0;
    @(posedge clk);
    #1;
  endtask
  // ------------
  // scenarios
  // ------------
  task automatic t_formats;
    logic [15:0] op [9] = '{16'h0000, 16'h581B, 16'h8000, 16'hA800, 16'hA000, 16'hC000,
                            16'hD000, 16'hD553, 16'h7800};
    for (int i = 0; i < 9; i++) begin
      issue(op[i], 16'hA82D, 4'h0);
      pc_m += (i >= 3 && i <= 7) ? 32'h00000004 : 32'h00000002;
      chk(pc_r, pc_m);
      chk(dec_fmt_r, 9'h001 << i);
      chk(dec_long_r, i >= 3 && i <= 7);
      chk(dec_valid_r, 1'b1);
      chk(dec_opcode_r, op[i][15:10]);
      chk(dec_subop_bit_r, op[i][0]);
      if (i == 1) begin
        chk(imm_signed_r, 32'hFFFFFFFB);
        chk(imm_operand_r, 32'h0000001B);
      end
      if (i == 4) chk(imm_signed_r, 32'hFFFFA82D);
      if (i == 7) begin
        chk({dec_third_reg_r, dec_second_reg_r, dec_src_reg_r}, 15'h5553);
        chk(dec_subop_r, 6'h2D);
      end
    end
    idle;
  endtask
  task automatic t_branch;
    issue(16'h81FE, 16'h0000, 4'h2);
    pc_m -= 32'h00000002;
    chk(pc_r, pc_m);
    issue(16'h9A20, 16'h0000, 4'h2);
    pc_m += 32'h00000020;
    chk(pc_r, pc_m);
    chk(dec_cond_r, 4'hD);
    issue(16'hAA00, 16'h0004, 4'h4);
    chk(link_addr_r, pc_m + 32'h00000004);
    pc_m += 32'hFE000004;
    chk(pc_r, pc_m);
    source_reg_val = 32'h12345677;
    issue(16'h0000, 16'h0000, 4'h8);
    pc_m = 32'h12345676;
    chk(pc_r, pc_m);
    idle;
  endtask
  task automatic t_mem;
    logic [31:0] exp_a [3] = '{32'h100000F2, 32'h100000F2, 32'h100000F0};
    logic [31:0] exp_ld [3] = '{32'hFFFFFFF2, 32'h0000F3F2, 32'hF3F2F1F0};
    logic [3:0]  exp_be [3] = '{4'h4, 4'hC, 4'hF};
    source_reg_val = 32'h100000F3;
    store_val = 32'hC3B2A1A5;
    sign_load = 1'b1;
    for (int s = 0; s < 3; s++) begin
      acc_size = 2'(s);
      io_space = s[0];
      // the halfword load runs unsigned so both extensions are seen
      sign_load = (s != 1);
      issue(16'hC000, 16'hFFFF, 4'h1);
      pc_m += 32'h00000004;
      chk(mem_valid_r, 1'b1);
      chk(mem_addr_r, exp_a[s]);
      chk(mem_byte_en_r, exp_be[s]);
      chk(mem_io_r, s[0]);
      chk(mem_wdata_r, s == 0 ? {4{8'hA5}} : s == 1 ? {2{16'hA1A5}} : store_val);
      idle;
      chk(load_val_r, exp_ld[s]);
    end
    chk(pc_r, pc_m);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    fetch_valid = 1'b0;
    {register_indirect_jump, jump_rel, take_branch, mem_req} = 4'h0;
    {io_space, sign_load, acc_size} = 4'h0;
    {fetch_lo_half, fetch_hi_half, source_reg_val, store_val} = 96'h0;
    pc_m = `PC_RESET;
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
    chk(pc_r, pc_m);
    chk(dec_fmt_r, `FMT_I);
    t_formats;
    t_branch;
    t_mem;
    conclude;
  end
  // the whole run needs well under a hundred cycles
  initial begin
    #20000;
    n_errors++;
    conclude;
  end
endmodule
